/* File: src/afs_pkg.sv */
// Package with field layout, widths and reset values of the front-end status register
package afs_pkg;
    // ------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------
    localparam int AFS_STATUS_W = 9;
    localparam int AFS_CHAN_N = 3;
    localparam int AFS_POS_PARITY = 0;
    localparam int AFS_POS_ALARM = 1;
    localparam int AFS_POS_WOKE_LSB = 2;
    localparam int AFS_POS_GAIN = 5;
    localparam int AFS_POS_ACTIVE_LSB = 6;
    localparam logic [8:0] AFS_STATUS_RST = 9'h001;
    localparam logic AFS_PARITY_RST = 1'b1;
    localparam logic AFS_ALARM_RST = 1'b0;
    localparam logic AFS_WOKE_RST = 1'b0;
    localparam logic AFS_ACTIVE_RST = 1'b0;
    localparam logic AFS_ALERT_N_RST = 1'b0;
endpackage : afs_pkg

/* File: src/afs_sticky_bit.sv */
// Sticky status bit: hardware set wins over any clear in the same cycle
`timescale 1ns/1ps
module afs_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic set,
    input wire logic clr,
    // State
    output logic q
);
    logic q_ff;
    logic nxt_q;

    assign nxt_q = set | (q_ff & ~clr);
    assign q = q_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q_ff <= RST_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule : afs_sticky_bit

/* File: src/afs_status_reg.sv */
// Nine-bit analog front end status register with alert output
`timescale 1ns/1ps
module afs_status_reg
    import afs_pkg::*;
(
    // Clock and reset (reset acts as front-end power-on reset)
    input wire logic clk,
    input wire logic resetn,
    // Command strobes from the serial command decoder
    input wire logic status_read_cmd,
    input wire logic soft_reset,
    // Event and level inputs from front-end logic
    input wire logic alarm_expired,
    input wire logic parity_err,
    input wire logic [2:0] chan_passing,
    input wire logic gain_ctrl_busy,
    input wire logic standby,
    input wire logic [2:0] chan_wake_evt,
    // Configuration register zero bit 4
    input wire logic alarm_alert_en,
    // Status outputs
    output logic [8:0] status_rdata,
    output logic status_rvalid,
    output logic [8:0] front_end_status,
    output logic alert_n
);
    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    logic parity_error_flag_ff;
    logic alarm_flag;
    logic [2:0] chan_woke;
    logic [2:0] chan_active_ff;
    logic gain_ctrl_active_ff;
    logic [8:0] status_rdata_ff;
    logic status_rvalid_ff;
    logic alert_n_ff;

    // Activity bits are level copies of the channel state; a sleep
    // command has no term here or anywhere else in the status update.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_active_ff <= {AFS_CHAN_N{AFS_ACTIVE_RST}};
            gain_ctrl_active_ff <= AFS_ACTIVE_RST;
        end else if (soft_reset) begin
            chan_active_ff <= {AFS_CHAN_N{AFS_ACTIVE_RST}};
            gain_ctrl_active_ff <= AFS_ACTIVE_RST;
        end else begin
            chan_active_ff <= chan_passing & {AFS_CHAN_N{~standby}};
            gain_ctrl_active_ff <= gain_ctrl_busy & ~standby;
        end
    end

    // Parity flag is real time; it survives soft reset and reads
    always_ff @(posedge clk) begin
        if (!resetn) begin
            parity_error_flag_ff <= AFS_PARITY_RST;
        end else begin
            parity_error_flag_ff <= parity_err;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // Alarm clears only on a status read, never on soft reset
    afs_sticky_bit #(
        .RST_VAL(AFS_ALARM_RST)
    ) u_alarm (
        .clk(clk),
        .resetn(resetn),
        .set(alarm_expired),
        .clr(status_read_cmd),
        .q(alarm_flag)
    );

    genvar gi;
    generate
        for (gi = 0; gi < AFS_CHAN_N; gi++) begin : g_woke
            afs_sticky_bit #(
                .RST_VAL(AFS_WOKE_RST)
            ) u_woke (
                .clk(clk),
                .resetn(resetn),
                .set(chan_wake_evt[gi]),
                .clr(soft_reset),
                .q(chan_woke[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path and alert
    // ------------------------------------------------------------
    function automatic logic [8:0] pack_status(
        input logic [2:0] act,
        input logic gain,
        input logic [2:0] woke,
        input logic alarm,
        input logic par
    );
        pack_status = {act, gain, woke, alarm, par};
    endfunction : pack_status

    assign front_end_status = pack_status(chan_active_ff, gain_ctrl_active_ff,
                                          chan_woke, alarm_flag, parity_error_flag_ff);

    // The read returns the value before the alarm is cleared, so a timeout
    // is reported once and not lost.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_rdata_ff <= AFS_STATUS_RST;
            status_rvalid_ff <= 1'b0;
        end else begin
            status_rvalid_ff <= status_read_cmd;
            if (status_read_cmd) begin
                status_rdata_ff <= front_end_status;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            alert_n_ff <= AFS_ALERT_N_RST;
        end else begin
            alert_n_ff <= ~(parity_error_flag_ff | (alarm_flag & alarm_alert_en));
        end
    end

    assign status_rdata = status_rdata_ff;
    assign status_rvalid = status_rvalid_ff;
    assign alert_n = alert_n_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_read_no_alarm;
        status_read_cmd && !alarm_expired;
    endsequence

    // A parity change in the read cycle is a legal update, not a read side effect
    sequence s_read_quiet;
        status_read_cmd && !soft_reset && (chan_wake_evt == 3'h0)
            && (parity_err == parity_error_flag_ff);
    endsequence

    property p_alarm_set;
        alarm_expired |=> alarm_flag;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

    property p_read_clears_alarm;
        s_read_no_alarm |=> !alarm_flag ##0 status_rvalid;
    endproperty
    a_read_clears_alarm: assert property (p_read_clears_alarm) else $error("read kept alarm");

    property p_read_keeps_woke;
        s_read_quiet |=> $stable(chan_woke) && $stable(parity_error_flag_ff);
    endproperty
    a_read_keeps_woke: assert property (p_read_keeps_woke) else $error("read changed bits");

    property p_alarm_alert;
        alarm_flag && alarm_alert_en |=> !alert_n;
    endproperty
    a_alarm_alert: assert property (p_alarm_alert) else $error("alarm alert missing");

    property p_parity_follow;
        parity_err |=> parity_error_flag_ff ##1 !alert_n;
    endproperty
    a_parity_follow: assert property (p_parity_follow) else $error("parity not tracked");

    property p_alert_release;
        !parity_error_flag_ff && !alarm_flag |=> alert_n;
    endproperty
    a_alert_release: assert property (p_alert_release) else $error("alert stuck low");

    property p_standby_idle;
        standby |=> (chan_active_ff == 3'h0) && !gain_ctrl_active_ff;
    endproperty
    a_standby_idle: assert property (p_standby_idle) else $error("active in standby");

    property p_por;
        !resetn |=> front_end_status == AFS_STATUS_RST;
    endproperty
    a_por: assert property (disable iff (1'b0) p_por) else $error("bad reset value");

    property p_soft_reset;
        soft_reset && !status_read_cmd && (chan_wake_evt == 3'h0) && !alarm_expired
            |=> (front_end_status[8:2] == 7'h00) && $stable(alarm_flag);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    property p_wake_set;
        chan_wake_evt != 3'h0 |=> (chan_woke & $past(chan_wake_evt)) == $past(chan_wake_evt);
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake not recorded");

    property p_read_snapshot;
        status_read_cmd |=> status_rdata == $past(front_end_status);
    endproperty
    a_read_snapshot: assert property (p_read_snapshot) else $error("read data wrong");

    property p_rvalid_pulse;
        !status_read_cmd |=> !status_rvalid;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray read valid");

    property p_parity_clear;
        !parity_err |=> !parity_error_flag_ff;
    endproperty
    a_parity_clear: assert property (p_parity_clear) else $error("parity flag stuck");

    property p_active_follow;
        !soft_reset && !standby |=> (chan_active_ff == $past(chan_passing))
            && (gain_ctrl_active_ff == $past(gain_ctrl_busy));
    endproperty
    a_active_follow: assert property (p_active_follow) else $error("activity not tracked");
endmodule : afs_status_reg

/* File: tb/afs_host_model.sv */
// Host model that issues read and soft-reset commands as one-cycle strobes
`timescale 1ns/1ps
module afs_host_model (
    // Clock
    input wire logic clk,
    // Command strobes
    output logic status_read_cmd,
    output logic soft_reset
);
    initial begin
        status_read_cmd = 1'b0;
        soft_reset = 1'b0;
    end
    // Strobe rises after a falling edge and is dropped one full cycle later
    task automatic send_cmd(input logic rd);
        @(negedge clk);
        if (rd) begin
            status_read_cmd = 1'b1;
        end else begin
            soft_reset = 1'b1;
        end
        @(negedge clk);
        status_read_cmd = 1'b0;
        soft_reset = 1'b0;
    endtask : send_cmd
endmodule : afs_host_model

/* File: tb/tb.sv */
// Self-checking bench for the front-end status register
`timescale 1ns/1ps
module tb;
    import afs_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic alarm_expired = 1'b0;
    logic parity_err = 1'b0;
    logic gain_ctrl_busy = 1'b0;
    logic standby = 1'b0;
    logic alarm_alert_en = 1'b1;
    logic [2:0] chan_passing = 3'h0;
    logic [2:0] chan_wake_evt = 3'h0;
    logic status_read_cmd, soft_reset, status_rvalid, alert_n;
    logic [8:0] status_rdata, front_end_status;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    initial forever #20 clk = ~clk;
    afs_host_model host (.clk(clk), .status_read_cmd(status_read_cmd), .soft_reset(soft_reset));
    afs_status_reg dut (.clk(clk), .resetn(resetn), .status_read_cmd(status_read_cmd),
        .soft_reset(soft_reset), .alarm_expired(alarm_expired), .parity_err(parity_err),
        .chan_passing(chan_passing), .gain_ctrl_busy(gain_ctrl_busy), .standby(standby),
        .chan_wake_evt(chan_wake_evt), .alarm_alert_en(alarm_alert_en),
        .status_rdata(status_rdata), .status_rvalid(status_rvalid),
        .front_end_status(front_end_status), .alert_n(alert_n));
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            err_total++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        tick(2);
        check("reset", front_end_status, AFS_STATUS_RST);
        check("alert rst", {8'h00, alert_n}, {8'h00, AFS_ALERT_N_RST});
        resetn = 1'b1;
        tick(2);
        check("parity off", front_end_status, 9'h000);
        check("alert idle", {8'h00, alert_n}, 9'h001);
        chan_passing = 3'h5;
        gain_ctrl_busy = 1'b1;
        tick(1);
        check("active", front_end_status, 9'h160);
        chan_wake_evt = 3'h6;
        tick(1);
        chan_wake_evt = 3'h0;
        tick(1);
        check("woke", front_end_status, 9'h178);
        standby = 1'b1;
        gain_ctrl_busy = 1'b0;
        tick(1);
        check("standby", front_end_status, 9'h018);
        standby = 1'b0;
        alarm_expired = 1'b1;
        tick(1);
        alarm_expired = 1'b0;
        check("alarm", front_end_status, 9'h15a);
        tick(1);
        check("alert alarm", {8'h00, alert_n}, 9'h000);
        // Idle cycles stand in for a sleep command, which reaches no port
        tick(3);
        check("sleep", front_end_status, 9'h15a);
        host.send_cmd(1'b1);
        check("rvalid", {8'h00, status_rvalid}, 9'h001);
        check("rdata", status_rdata, 9'h15a);
        check("read clr", front_end_status, 9'h158);
        tick(1);
        check("alert back", {8'h00, alert_n}, 9'h001);
        check("rvalid end", {8'h00, status_rvalid}, 9'h000);
        alarm_alert_en = 1'b0;
        alarm_expired = 1'b1;
        tick(1);
        alarm_expired = 1'b0;
        tick(1);
        check("alert masked", {8'h00, alert_n}, 9'h001);
        host.send_cmd(1'b0);
        check("soft rst", front_end_status, 9'h002);
        tick(1);
        check("reload", front_end_status, 9'h142);
        parity_err = 1'b1;
        tick(2);
        check("parity", front_end_status, 9'h143);
        check("alert par", {8'h00, alert_n}, 9'h000);
        parity_err = 1'b0;
        tick(2);
        check("parity gone", front_end_status, 9'h142);
        check("alert free", {8'h00, alert_n}, 9'h001);
        final_report();
    end
endmodule : tb
